// ===== dv/line_interface_config_chk.sv
// Port assertions for the configuration register bank
`timescale 1ns/1ps
module line_interface_config_chk
(
    input wire        clk_i,
    input wire        reset_n_i,
    input wire [4:0]  reg_addr_i,
    input wire [7:0]  reg_wdata_i,
    input wire        reg_wr_i,
    input wire        reg_rd_i,
    input wire [7:0]  reg_rdata_o,
    input wire        hw_mode_i,
    input wire [2:0]  hw_synth_select_i,
    input wire        tx_positive_rail_o,
    input wire        tx_negative_rail_o,
    input wire [2:0]  synth_input_select_o,
    input wire [11:0] synth_ref_khz_o,
    input wire        soft_reset_o
);
    // Reference kHz per select code, code 0 in the lowest 12 bits
    localparam [95:0] REF_KHZ = {12'h100, 12'h080, 12'h040, 12'h038,
                                 12'h010, 12'h008, 12'h608, 12'h800};
    // ------------------------------------------------------------------
    // Shadow of the line control register
    // ------------------------------------------------------------------
    reg  [7:0] ctrl_r;
    reg  [8:0] age_r;
    wire       ctrl_wr = reg_wr_i && reg_addr_i == 5'h10;
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ctrl_r <= 8'h00;
            age_r  <= 9'h000;
        end
        else
        begin
            if (ctrl_wr)
                ctrl_r <= reg_wdata_i;
            // Saturates so a long hold never wraps into a false match
            age_r <= ctrl_wr ? 9'h000 : age_r + {8'h00, age_r != 9'h1ff};
        end
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_unmapped_reads_zero: assert property (reg_rd_i &&
        !(reg_addr_i inside {5'h10, 5'h11}) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_read_back: assert property (reg_rd_i &&
        reg_addr_i == 5'h10 |=> reg_rdata_o == $past(ctrl_r))
        else $error("line control read back wrong");
    a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_pin_select: assert property ((hw_mode_i &&
        $stable(hw_synth_select_i)) [*5] |->
        synth_input_select_o == hw_synth_select_i)
        else $error("pin select not taken in hardware mode");
    a_ref_table: assert property ($stable(synth_input_select_o) [*3] |->
        synth_ref_khz_o == REF_KHZ[synth_input_select_o * 12 +: 12])
        else $error("reference frequency wrong for code");
    a_soft_rst_fall: assert property (ctrl_wr && !reg_wdata_i[0] |=>
        ##1 !soft_reset_o)
        else $error("soft reset outlived its bit");
    a_soft_rst_rise: assert property ($rose(soft_reset_o) |->
        ctrl_r[0] && age_r == 9'h0fb)
        else $error("soft reset rose at wrong count");
    a_soft_rst_force: assert property (soft_reset_o [*2] |->
        !tx_positive_rail_o && !tx_negative_rail_o)
        else $error("transmit rails not forced in soft reset");
    c_soft_reset: cover property ($rose(soft_reset_o));
    c_pin_mode: cover property (hw_mode_i && synth_input_select_o == 3'h7);
    c_ctrl_read: cover property (reg_rd_i && reg_addr_i == 5'h10);
endmodule
bind line_interface_config_regs line_interface_config_chk chk
(
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .hw_mode_i(hw_mode_i),
    .hw_synth_select_i(hw_synth_select_i),
    .tx_positive_rail_o(tx_positive_rail_o),
    .tx_negative_rail_o(tx_negative_rail_o),
    .synth_input_select_o(synth_input_select_o),
    .synth_ref_khz_o(synth_ref_khz_o), .soft_reset_o(soft_reset_o)
);

// ===== dv/tb_top.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module tb_top;
    reg         clk_i       = 1'b0;
    reg         reset_n_i   = 1'b0;
    reg  [4:0]  addr        = 5'h00;
    reg  [7:0]  wdata       = 8'h00;
    reg         wr_s        = 1'b0;
    reg         rd_s        = 1'b0;
    reg         hw_mode     = 1'b0;
    reg  [2:0]  hw_sel      = 3'h0;
    reg         hw_rate     = 1'b0;
    reg         los         = 1'b0;
    reg         lclk        = 1'b0;
    reg  [3:0]  din         = 4'h0;
    reg  [31:0] seed        = 32'h0000_6413;
    reg  [7:0]  cfg;
    integer     i;
    integer     num_errors  = 0;
    integer     checks_done = 0;
    wire [7:0]  rdata;
    wire [3:0]  dout;
    wire [2:0]  sel;
    wire        rate;
    wire        srst;
    line_interface_config_regs uut
    (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
        .reg_rdata_o(rdata), .hw_mode_i(hw_mode),
        .hw_synth_select_i(hw_sel), .hw_master_rate_i(hw_rate),
        .rx_loss_of_signal_i(los), .tx_line_clock_i(lclk),
        .tx_positive_rail_in_i(din[3]), .tx_negative_rail_in_i(din[2]),
        .rx_clock_i(lclk), .rx_positive_rail_i(din[1]),
        .rx_negative_rail_i(din[0]), .tx_positive_rail_o(dout[3]),
        .tx_negative_rail_o(dout[2]), .rx_positive_rail_o(dout[1]),
        .rx_negative_rail_o(dout[0]), .synth_input_select_o(sel),
        .master_rate_select_o(rate), .synth_ref_khz_o(),
        .soft_reset_o(srst)
    );
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------------
    // Helpers, all entered and left at a falling edge
    // ------------------------------------------------------------------
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
    begin
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    end
    endfunction
    // Rails after one rising then one falling line clock edge
    function [3:0] exp_line(input [7:0] c, input [3:0] a, input [3:0] b,
                            input l);
        reg [3:0] t;
    begin
        t[3:2] = (c[4] ? a[3:2] : b[3:2]) ^ {2{c[3]}};
        t[1:0] = (c[5] ? b[1:0] : a[1:0]) ^ {2{c[3]}};
        if (c[7])
            t[2] = 1'b0;
        if (c[7])
            t[0] = c[3];
        if (c[6] && l)
            t[3:2] = 2'h2;
        exp_line = t;
    end
    endfunction
    task print_verdict;
    begin
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    task chk(input [95:0] name, input [11:0] exp, input [11:0] got);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("Error %0s expected %h seen %h", name, exp, got);
        end
    end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk_i);
    endtask
    task reg_write(input [4:0] a, input [7:0] d);
    begin
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        cyc(1);
        wr_s = 1'b0;
        // Idle cycle keeps back-to-back strobes apart
        cyc(1);
    end
    endtask
    task reg_read(input [4:0] a, input [7:0] e);
    begin
        addr = a;
        rd_s = 1'b1;
        cyc(1);
        rd_s = 1'b0;
        cyc(1);
        chk("rdata", {4'h0, e}, {4'h0, rdata});
    end
    endtask
    // Line clock period of 24 system clocks, data moved between edges
    task line_cycle(input [7:0] c, input l);
        reg [3:0] a;
        reg [3:0] b;
    begin
        seed = xs(seed);
        a = seed[3:0];
        b = seed[7:4];
        los = l;
        din = a;
        cyc(6);
        lclk = 1'b1;
        cyc(6);
        din = b;
        cyc(6);
        lclk = 1'b0;
        cyc(6);
        chk("rails", {8'h00, exp_line(c, a, b, l)}, {8'h00, dout});
    end
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        cyc(8);
        reset_n_i = 1'b1;
        reg_read(5'h10, 8'h00);
        reg_read(5'h11, 8'h00);
        reg_read(5'h12, 8'h00);
        reg_write(5'h13, 8'hff);
        reg_read(5'h13, 8'h00);
        for (i = 0; i < 16; i = i + 1)
        begin
            seed = xs(seed);
            cfg = {seed[7], i[3:0], seed[2:0]};
            reg_write(5'h11, cfg);
            reg_read(5'h11, cfg);
            chk("select", {9'h000, i[3:1]}, {9'h000, sel});
            chk("rate", {11'h000, i[0]}, {11'h000, rate});
        end
        seed = xs(seed);
        hw_sel = seed[2:0];
        hw_rate = seed[3];
        hw_mode = 1'b1;
        cyc(8);
        chk("pin_select", {9'h000, hw_sel}, {9'h000, sel});
        chk("pin_rate", {11'h000, hw_rate}, {11'h000, rate});
        hw_mode = 1'b0;
        reg_write(5'h10, 8'hc0);
        line_cycle(8'hc0, 1'b1);
        for (i = 0; i < 24; i = i + 1)
        begin
            seed = xs(seed);
            cfg = {seed[15:9], 1'b0};
            reg_write(5'h10, cfg);
            reg_read(5'h10, cfg);
            line_cycle(cfg, seed[16] & ~cfg[3]);
        end
        reg_write(5'h10, 8'h09);
        cyc(200);
        chk("early_reset", 12'h000, {11'h000, srst});
        i = 0;
        while (srst !== 1'b1 && i < 100)
        begin
            cyc(1);
            i = i + 1;
        end
        if (srst !== 1'b1)
        begin
            num_errors = num_errors + 1;
            $display("Error soft_reset expected 1 seen %b", srst);
        end
        else
        begin
            cyc(3);
            chk("forced", 12'h003, {8'h00, dout});
            reg_write(5'h10, 8'h08);
            cyc(2);
            chk("reset_off", 12'h000, {11'h000, srst});
        end
        print_verdict;
    end
endmodule

// ===== src/line_interface_config_defines.vh
// Register offsets, field positions, reset values and timing counts
`ifndef LINE_INTERFACE_CONFIG_DEFINES_VH
`define LINE_INTERFACE_CONFIG_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define LIC_OFFSET_LINE_CTRL     5'h10
`define LIC_OFFSET_SYNTH_SEL     5'h11

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LIC_RESET_LINE_CTRL      8'h00
`define LIC_RESET_SYNTH_SEL      8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LIC_BIT_RAIL_FORMAT      7
`define LIC_BIT_AUTO_ONES        6
`define LIC_BIT_RX_EDGE          5
`define LIC_BIT_TX_EDGE          4
`define LIC_BIT_POLARITY         3
`define LIC_BIT_SOFT_RESET       0
`define LIC_BIT_SEL_MSB          6
`define LIC_BIT_SEL_MID          5
`define LIC_BIT_SEL_LSB          4
`define LIC_BIT_MASTER_RATE      3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// Cycles of the 25 MHz clock in 10 us; the bit must outlast this
`define LIC_SOFT_RST_CYCLES      9'h0fa

`endif

// ===== src/line_interface_config_regs.v
// Line interface configuration registers and the data path they steer
//
// What this block does
// - D7 one single rail, zero dual rail
// - D6 sends all ones during receive LOS
// - D5 one: receive data changes on falling
// - D4 zero: transmit sampled on falling edge
// - D3 one makes data active low
// - D0 held over 10us resets state machines
// - Codes 011..111 select 16/56/64/128/256 kHz
// - Rate bit zero E1, one T1/J1
// - Hardware mode takes synthesizer setup from pins
`timescale 1ns/1ps
`include "line_interface_config_defines.vh"

module line_interface_config_regs
(
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire [4:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [7:0]  reg_rdata_o,
    input  wire        hw_mode_i,
    input  wire [2:0]  hw_synth_select_i,
    input  wire        hw_master_rate_i,
    input  wire        rx_loss_of_signal_i,
    input  wire        tx_line_clock_i,
    input  wire        tx_positive_rail_in_i,
    input  wire        tx_negative_rail_in_i,
    input  wire        rx_clock_i,
    input  wire        rx_positive_rail_i,
    input  wire        rx_negative_rail_i,
    output reg         tx_positive_rail_o,
    output reg         tx_negative_rail_o,
    output reg         rx_positive_rail_o,
    output reg         rx_negative_rail_o,
    output reg  [2:0]  synth_input_select_o,
    output reg         master_rate_select_o,
    output reg  [11:0] synth_ref_khz_o,
    output reg         soft_reset_o
);

    localparam [8:0] SOFT_RST_CYCLES = `LIC_SOFT_RST_CYCLES;

    // ------------------------------------------------------------------
    // Reference frequency lookup
    // ------------------------------------------------------------------
    function [11:0] ref_khz;
        input [2:0] code;
        begin
            case (code)
                3'b000:  ref_khz = 12'h800;
                3'b001:  ref_khz = 12'h608;
                3'b010:  ref_khz = 12'h008;
                3'b011:  ref_khz = 12'h010;
                3'b100:  ref_khz = 12'h038;
                3'b101:  ref_khz = 12'h040;
                3'b110:  ref_khz = 12'h080;
                3'b111:  ref_khz = 12'h100;
                default: ref_khz = 12'h800;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg [7:0] line_interface_control_r;
    reg [7:0] clock_synth_select_r;

    wire rail_format_select    =
        line_interface_control_r[`LIC_BIT_RAIL_FORMAT];
    wire auto_all_ones_on_los  =
        line_interface_control_r[`LIC_BIT_AUTO_ONES];
    wire rx_output_edge_select = line_interface_control_r[`LIC_BIT_RX_EDGE];
    wire tx_sample_edge_select = line_interface_control_r[`LIC_BIT_TX_EDGE];
    wire data_polarity_select  =
        line_interface_control_r[`LIC_BIT_POLARITY];
    wire soft_reset_bit        =
        line_interface_control_r[`LIC_BIT_SOFT_RESET];

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            line_interface_control_r <= `LIC_RESET_LINE_CTRL;
            clock_synth_select_r     <= `LIC_RESET_SYNTH_SEL;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                `LIC_OFFSET_LINE_CTRL: line_interface_control_r <= reg_wdata_i;
                `LIC_OFFSET_SYNTH_SEL: clock_synth_select_r     <= reg_wdata_i;
                default:
                begin
                end
            endcase
        end
    end

    // Unmapped addresses read as zero
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                `LIC_OFFSET_LINE_CTRL: reg_rdata_o <= line_interface_control_r;
                `LIC_OFFSET_SYNTH_SEL: reg_rdata_o <= clock_synth_select_r;
                default:               reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    reg [11:0] meta_r;
    reg [11:0] sync_r;

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta_r <= 12'h000;
            sync_r <= 12'h000;
        end
        else
        begin
            meta_r <= {hw_mode_i, hw_synth_select_i, hw_master_rate_i,
                       rx_loss_of_signal_i, tx_line_clock_i,
                       tx_positive_rail_in_i, tx_negative_rail_in_i,
                       rx_clock_i, rx_positive_rail_i, rx_negative_rail_i};
            sync_r <= meta_r;
        end
    end

    wire       hw_mode_s     = sync_r[11];
    wire [2:0] hw_select_s   = sync_r[10:8];
    wire       hw_rate_s     = sync_r[7];
    wire       rx_los_s      = sync_r[6];
    wire       tx_clk_s      = sync_r[5];
    wire       tx_pos_s      = sync_r[4];
    wire       tx_neg_s      = sync_r[3];
    wire       rx_clk_s      = sync_r[2];
    wire       rx_pos_s      = sync_r[1];
    wire       rx_neg_s      = sync_r[0];

    // ------------------------------------------------------------------
    // Soft reset timer
    // ------------------------------------------------------------------
    reg [8:0] soft_cnt_r;
    reg [8:0] soft_cnt_nxt;

    always @*
    begin
        soft_cnt_nxt = soft_cnt_r;
        if (!soft_reset_bit)
            soft_cnt_nxt = 9'h000;
        else if (soft_cnt_r <= SOFT_RST_CYCLES)
            soft_cnt_nxt = soft_cnt_r + 9'h001;
    end

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            soft_cnt_r   <= 9'h000;
            soft_reset_o <= 1'b0;
        end
        else
        begin
            soft_cnt_r   <= soft_cnt_nxt;
            // reset once held longer than limit
            soft_reset_o <= soft_reset_bit && (soft_cnt_nxt > SOFT_RST_CYCLES);
        end
    end

    // ------------------------------------------------------------------
    // Clock synthesizer selection
    // ------------------------------------------------------------------
    wire [2:0] reg_select =
        clock_synth_select_r[`LIC_BIT_SEL_MSB:`LIC_BIT_SEL_LSB];

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            synth_input_select_o <= 3'b000;
            master_rate_select_o <= 1'b0;
            synth_ref_khz_o      <= 12'h800;
        end
        else if (hw_mode_s)
        begin
            synth_input_select_o <= hw_select_s;
            master_rate_select_o <= hw_rate_s;
            synth_ref_khz_o      <= ref_khz(hw_select_s);
        end
        else
        begin
            synth_input_select_o <= reg_select;
            master_rate_select_o <= clock_synth_select_r[`LIC_BIT_MASTER_RATE];
            synth_ref_khz_o      <= ref_khz(reg_select);
        end
    end

    // ------------------------------------------------------------------
    // Transmit and receive data path
    // ------------------------------------------------------------------
    // Edges seen on the synchronised clocks, so line rate must stay
    // well below a quarter of clk_i
    reg tx_clk_d_r;
    reg rx_clk_d_r;

    wire tx_rise = tx_clk_s & ~tx_clk_d_r;
    wire tx_fall = ~tx_clk_s & tx_clk_d_r;
    wire rx_rise = rx_clk_s & ~rx_clk_d_r;
    wire rx_fall = ~rx_clk_s & rx_clk_d_r;

    wire tx_take = tx_sample_edge_select ? tx_rise : tx_fall;
    wire rx_take = rx_output_edge_select ? rx_fall : rx_rise;

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            tx_clk_d_r         <= 1'b0;
            rx_clk_d_r         <= 1'b0;
            tx_positive_rail_o <= 1'b0;
            tx_negative_rail_o <= 1'b0;
            rx_positive_rail_o <= 1'b0;
            rx_negative_rail_o <= 1'b0;
        end
        // soft reset drives the transmit rails low and the receive rails to the polarity bit
        else if (soft_reset_o)
        begin
            tx_clk_d_r         <= tx_clk_s;
            rx_clk_d_r         <= rx_clk_s;
            tx_positive_rail_o <= 1'b0;
            tx_negative_rail_o <= 1'b0;
            rx_positive_rail_o <= data_polarity_select;
            rx_negative_rail_o <= data_polarity_select;
        end
        else
        begin
            tx_clk_d_r <= tx_clk_s;
            rx_clk_d_r <= rx_clk_s;
            if (tx_take)
            begin
                // all ones during loss of signal
                if (auto_all_ones_on_los && rx_los_s)
                begin
                    tx_positive_rail_o <= 1'b1;
                    tx_negative_rail_o <= 1'b0;
                end
                else
                begin
                    tx_positive_rail_o <= tx_pos_s ^ data_polarity_select;
                    tx_negative_rail_o <= rail_format_select ? 1'b0 :
                                          (tx_neg_s ^ data_polarity_select);
                end
            end
            if (rx_take)
            begin
                rx_positive_rail_o <= rx_pos_s ^ data_polarity_select;
                rx_negative_rail_o <= rail_format_select ?
                                      data_polarity_select :
                                      (rx_neg_s ^ data_polarity_select);
            end
        end
    end

endmodule
